// [rtl/dynwidth_defs.svh]
`ifndef DYNWIDTH_DEFS_SVH
`define DYNWIDTH_DEFS_SVH

// Command codes carried in the command byte.
`define CMD_DATA_WRITE 4'h0
`define CMD_DATA_READ 4'h1
`define CMD_READ_LINE_STATUS 4'h2
`define CMD_WRITE_LINE_STATUS 4'h3
`define CMD_BUF_FLUSH 4'h4
`define CMD_NV_ADDR 4'h5
`define CMD_NV_WRITE 4'h6
`define CMD_NV_READ 4'h7
`define CMD_USB_STATE 4'h8

// Byte positions of the command code bits inside the command byte.
`define CMD_POS_B3 0
`define CMD_POS_B2 3
`define CMD_POS_B1 5
`define CMD_POS_B0 6

// Levels driven on the master-input line at the start of each data byte.
`define ACK_LEVEL 1'b0
`define NAK_LEVEL 1'b1

`endif

// [rtl/dynwidth_pkg.sv]
`include "dynwidth_defs.svh"

package dynwidth_pkg;

    typedef enum logic [1:0] {
        WIDTH_1 = 2'b00,
        WIDTH_2 = 2'b01,
        WIDTH_4 = 2'b10
    } width_type;

    // What the link side reports to the system side.
    typedef struct packed {
        logic cmd_valid;
        logic [3:0] cmd;
        logic byte_tgl;
        logic [7:0] rx_byte;
    } link_report_type;

    // Bytes the system side offers for read commands.
    typedef struct packed {
        logic [7:0] rd_byte;
        logic [7:0] nv_byte;
        logic [1:0] line_status;
        logic [1:0] usb_state;
    } tx_sources_type;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
        logic miso_out;
        logic miso_oe;
    } pin_drive_type;

    typedef struct packed {
        logic started;
        logic cmd_done;
        width_type width;
        logic [2:0] k;
        logic [7:0] shreg;
        logic [3:0] cmd;
    } sample_state_type;

    typedef struct packed {
        logic byte_tgl;
        logic [7:0] rx_byte;
    } hold_type;

    typedef struct packed {
        logic [2:0] k;
        logic [7:0] txsh;
        pin_drive_type pins;
    } drive_state_type;

    typedef struct packed {
        logic valid_seen;
        logic tgl_ref;
        logic [3:0] cmd;
        logic cpol;
        logic lsb_first;
        logic idle_en;
        logic idle_oe;
        logic idle_d0;
        logic idle_miso;
        tx_sources_type tx;
        logic [7:0] wr_byte;
        logic wr_valid;
        logic rd_pop;
        logic [3:0] modem_in;
        logic flush;
        logic [7:0] nv_addr;
        logic [7:0] nv_wr_data;
        logic nv_wr_strobe;
    } sys_state_type;

    function automatic logic [3:0] lane_count(input width_type w);
        case (w)
            WIDTH_4: return 4'h4;
            WIDTH_2: return 4'h2;
            default: return 4'h1;
        endcase
    endfunction : lane_count

    function automatic logic [2:0] last_chunk(input width_type w);
        case (w)
            WIDTH_4: return 3'h1;
            WIDTH_2: return 3'h3;
            default: return 3'h7;
        endcase
    endfunction : last_chunk

    // Bit of the byte carried by a lane in chunk k; MSB first sends high chunks first.
    function automatic logic [2:0] bit_index(input logic [2:0] k, input width_type w,
                                             input logic [1:0] lane, input logic lsb_first);
        logic [3:0] base;
        base = {1'b0, k} * lane_count(w);
        if (lsb_first) begin
            return 3'(base + {2'h0, lane});
        end
        return 3'(4'h8 - lane_count(w) - base + {2'h0, lane});
    endfunction : bit_index

    function automatic logic [7:0] place_chunk(input logic [7:0] sh, input logic [3:0] d,
                                               input logic [2:0] k, input width_type w,
                                               input logic lsb_first);
        logic [7:0] r;
        r = sh;
        for (int i = 0; i < 4; i++) begin
            if (4'(i) < lane_count(w)) begin
                r[bit_index(k, w, 2'(i), lsb_first)] = d[i];
            end
        end
        return r;
    endfunction : place_chunk

    function automatic logic is_read(input logic [3:0] c);
        return c == `CMD_DATA_READ || c == `CMD_READ_LINE_STATUS ||
               c == `CMD_NV_READ || c == `CMD_USB_STATE;
    endfunction : is_read

    function automatic logic has_data(input logic [3:0] c);
        return c <= `CMD_USB_STATE && c != `CMD_BUF_FLUSH;
    endfunction : has_data

endpackage : dynwidth_pkg

// [rtl/dynwidth_serial_slave_cmd.sv]
`include "dynwidth_defs.svh"

module dynwidth_serial_slave_cmd (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic [3:0] data_in,
    output logic [3:0] data_out,
    output logic [3:0] data_oe,
    output logic miso_out,
    output logic miso_oe,
    input wire logic cfg_cpol,
    input wire logic cfg_lsb_first,
    input wire logic cfg_idle_status_en,
    input wire logic write_space_avail,
    input wire logic read_data_avail,
    input wire logic [7:0] rd_byte,
    input wire logic [7:0] nv_rd_data,
    input wire logic rts,
    input wire logic dtr,
    input wire logic [1:0] usb_state,
    output logic [7:0] wr_byte,
    output logic wr_byte_valid,
    output logic rd_byte_pop,
    output logic [3:0] modem_in,
    output logic flush_req,
    output logic [7:0] nv_addr,
    output logic [7:0] nv_wr_data,
    output logic nv_wr_strobe
);
    dynwidth_pkg::sample_state_type smp_reg;
    dynwidth_pkg::sample_state_type smp_next;
    dynwidth_pkg::hold_type hold_reg;
    dynwidth_pkg::hold_type hold_next;
    dynwidth_pkg::drive_state_type drv_reg;
    dynwidth_pkg::drive_state_type drv_next;
    dynwidth_pkg::sys_state_type sys_reg;
    dynwidth_pkg::sys_state_type sys_next;
    dynwidth_pkg::link_report_type rep;
    logic sclk_e;
    logic [1:0] ack_link;
    logic ack_now;
    logic [2:0] sys_sync;
    logic idle;
    logic cmd_event;
    logic byte_event;
    logic smp_last;
    logic drv_last;
    logic [7:0] tx_src;

    // Both supported modes sample on the trailing edge, so folding the
    // polarity into the clock lets one edge pair serve modes 1 and 3.
    assign sclk_e = sclk ^ sys_reg.cpol;

    assign smp_last = smp_reg.k == dynwidth_pkg::last_chunk(smp_reg.width);

    // Sample side: width decode, command assembly, then data bytes.
    always_comb begin
        smp_next = smp_reg;
        hold_next = hold_reg;
        if (!smp_reg.started) begin
            smp_next.started = 1'b1;
            // Unused lines float high through the pad pull-ups.
            if (!data_in[3] || !data_in[2]) begin
                smp_next.width = dynwidth_pkg::WIDTH_4;
            end else if (!data_in[1]) begin
                smp_next.width = dynwidth_pkg::WIDTH_2;
            end else begin
                smp_next.width = dynwidth_pkg::WIDTH_1;
            end
            smp_next.shreg = dynwidth_pkg::place_chunk(8'h00, data_in, 3'h0,
                                                       smp_next.width, 1'b1);
            smp_next.k = 3'h1;
            hold_next.byte_tgl = 1'b0;
        end else begin
            // The command byte always uses fixed positions; data follows the setting.
            smp_next.shreg = dynwidth_pkg::place_chunk(smp_reg.shreg, data_in, smp_reg.k,
                smp_reg.width, smp_reg.cmd_done ? sys_reg.lsb_first : 1'b1);
            smp_next.k = smp_last ? 3'h0 : smp_reg.k + 3'h1;
            if (!smp_reg.cmd_done) begin
                if (smp_last) begin
                    smp_next.cmd_done = 1'b1;
                    smp_next.cmd = {smp_next.shreg[`CMD_POS_B3], smp_next.shreg[`CMD_POS_B2],
                                    smp_next.shreg[`CMD_POS_B1],
                                    smp_next.shreg[`CMD_POS_B0]};
                end
            end else if (dynwidth_pkg::is_read(smp_reg.cmd)) begin
                // A read byte counts as taken at its first sample edge.
                if (smp_reg.k == 3'h0) begin
                    hold_next.byte_tgl = ~hold_reg.byte_tgl;
                end
            end else if (smp_last && dynwidth_pkg::has_data(smp_reg.cmd)) begin
                hold_next.rx_byte = smp_next.shreg;
                hold_next.byte_tgl = ~hold_reg.byte_tgl;
            end
        end
    end

    // Select high clears the sample state at once, dropping a partial byte.
    always_ff @(negedge sclk_e or posedge ss_n) begin
        if (ss_n) begin
            smp_reg <= '0;
        end else begin
            smp_reg <= smp_next;
        end
    end

    // The toggle and received byte survive select release, so the system
    // side never sees a spurious event when the frame ends.
    always_ff @(negedge sclk_e) begin
        hold_reg <= hold_next;
    end

    // Both buffer levels cross into the link clock, and the link picks by its own
    // command; the link clock stops between frames, so a level chosen by the system
    // side's command would still belong to the previous frame.
    sync2 #(
        .W(2)
    ) u_ack_sync (
        .clk(sclk_e),
        .en(1'b1),
        .rst_n(1'b1),
        .d({sys_reg.idle_d0, sys_reg.idle_miso}),
        .q(ack_link)
    );

    assign ack_now = (smp_reg.cmd == `CMD_DATA_WRITE) ? ack_link[1] :
                     (smp_reg.cmd == `CMD_DATA_READ) ? ack_link[0] : 1'b1;

    // Read bytes are chosen by the link's own command from sources that the
    // system side refreshes continuously, so no round trip is needed.
    always_comb begin
        case (smp_reg.cmd)
            `CMD_DATA_READ: tx_src = sys_reg.tx.rd_byte;
            `CMD_READ_LINE_STATUS: tx_src = {6'h00, sys_reg.tx.line_status};
            `CMD_NV_READ: tx_src = sys_reg.tx.nv_byte;
            `CMD_USB_STATE: tx_src = {6'h00, sys_reg.tx.usb_state};
            default: tx_src = 8'h00;
        endcase
        if (drv_reg.k != 3'h0) begin
            tx_src = drv_reg.txsh;
        end
    end

    assign drv_last = drv_reg.k == dynwidth_pkg::last_chunk(smp_reg.width);

    // Drive side: ack at each byte start and read data chunks.
    always_comb begin
        drv_next = drv_reg;
        if (smp_reg.cmd_done && dynwidth_pkg::has_data(smp_reg.cmd)) begin
            drv_next.k = drv_last ? 3'h0 : drv_reg.k + 3'h1;
            drv_next.pins.miso_oe = 1'b1;
            if (drv_reg.k == 3'h0) begin
                drv_next.pins.miso_out = ack_now ? `ACK_LEVEL : `NAK_LEVEL;
            end
            if (dynwidth_pkg::is_read(smp_reg.cmd)) begin
                drv_next.txsh = tx_src;
                for (int i = 0; i < 4; i++) begin
                    if (4'(i) < dynwidth_pkg::lane_count(smp_reg.width)) begin
                        drv_next.pins.oe[i] = 1'b1;
                        drv_next.pins.out[i] = tx_src[dynwidth_pkg::bit_index(drv_reg.k,
                            smp_reg.width, 2'(i), sys_reg.lsb_first)];
                    end
                end
            end
        end
    end

    // Odd edges drive; the command phase leaves the lines to the master.
    always_ff @(posedge sclk_e or posedge ss_n) begin
        if (ss_n) begin
            drv_reg <= '0;
        end else begin
            drv_reg <= drv_next;
        end
    end

    assign rep = '{cmd_valid: smp_reg.cmd_done, cmd: smp_reg.cmd,
                   byte_tgl: hold_reg.byte_tgl, rx_byte: hold_reg.rx_byte};

    // Select, command-valid and the byte toggle cross into the system clock.
    sync2 #(
        .W(3)
    ) u_sys_sync (
        .clk(clk_sys),
        .en(clk_en),
        .rst_n(rst_n),
        .d({ss_n, rep.cmd_valid, rep.byte_tgl}),
        .q(sys_sync)
    );

    assign idle = sys_sync[2];
    assign cmd_event = sys_sync[1] && !sys_reg.valid_seen;
    assign byte_event = sys_sync[1] && sys_reg.valid_seen && sys_sync[0] != sys_reg.tgl_ref;

    // System side: configuration, idle status and command effects.
    always_comb begin
        sys_next = sys_reg;
        sys_next.wr_valid = 1'b0;
        sys_next.rd_pop = 1'b0;
        sys_next.flush = 1'b0;
        sys_next.nv_wr_strobe = 1'b0;
        sys_next.valid_seen = sys_sync[1];
        // Settings only change between frames so a frame never sees a mix.
        if (idle) begin
            sys_next.cpol = cfg_cpol;
            sys_next.lsb_first = cfg_lsb_first;
            sys_next.idle_en = cfg_idle_status_en;
        end
        sys_next.idle_oe = idle && sys_reg.idle_en;
        sys_next.idle_d0 = write_space_avail;
        sys_next.idle_miso = read_data_avail;
        sys_next.tx = '{rd_byte: rd_byte, nv_byte: nv_rd_data,
                        line_status: {rts, dtr}, usb_state: usb_state};
        if (cmd_event) begin
            sys_next.cmd = rep.cmd;
            sys_next.tgl_ref = sys_sync[0];
            if (rep.cmd == `CMD_BUF_FLUSH) begin
                sys_next.flush = 1'b1;
            end
        end
        if (byte_event) begin
            sys_next.tgl_ref = ~sys_reg.tgl_ref;
            case (sys_reg.cmd)
                `CMD_DATA_WRITE: begin
                    sys_next.wr_byte = rep.rx_byte;
                    sys_next.wr_valid = 1'b1;
                end
                `CMD_DATA_READ: sys_next.rd_pop = 1'b1;
                `CMD_WRITE_LINE_STATUS: sys_next.modem_in = rep.rx_byte[3:0];
                `CMD_NV_ADDR: sys_next.nv_addr = rep.rx_byte;
                `CMD_NV_WRITE: begin
                    sys_next.nv_wr_data = rep.rx_byte;
                    sys_next.nv_wr_strobe = 1'b1;
                end
                // Other read bytes only need the toggle reference to follow.
                default: begin
                end
            endcase
        end
    end

    // Synchronous reset; the clock enable freezes all system state.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sys_reg <= '0;
        end else if (clk_en) begin
            sys_reg <= sys_next;
        end
    end

    // The pin drive hands over on the raw select so the turnaround is immediate.
    assign data_out = ss_n ? {3'h0, sys_reg.idle_d0} : drv_reg.pins.out;
    assign data_oe = ss_n ? {3'h0, sys_reg.idle_oe} : drv_reg.pins.oe;
    assign miso_out = ss_n ? sys_reg.idle_miso : drv_reg.pins.miso_out;
    assign miso_oe = ss_n ? sys_reg.idle_oe : drv_reg.pins.miso_oe;
    assign wr_byte = sys_reg.wr_byte;
    assign wr_byte_valid = sys_reg.wr_valid;
    assign rd_byte_pop = sys_reg.rd_pop;
    assign modem_in = sys_reg.modem_in;
    assign flush_req = sys_reg.flush;
    assign nv_addr = sys_reg.nv_addr;
    assign nv_wr_data = sys_reg.nv_wr_data;
    assign nv_wr_strobe = sys_reg.nv_wr_strobe;

    // Link-side checks.
    sequence first_edge_s;
        !smp_reg.started;
    endsequence

    sequence nibble_cmd_s;
        first_edge_s and !data_in[2] ##1 1'b1;
    endsequence

    width4_a: assert property (@(negedge sclk_e) disable iff (ss_n)
        first_edge_s and (!data_in[3] || !data_in[2]) |=>
        smp_reg.width == dynwidth_pkg::WIDTH_4) else $error("four-lane decode wrong");
    width2_a: assert property (@(negedge sclk_e) disable iff (ss_n)
        first_edge_s and (data_in[3:1] == 3'h6) |=>
        smp_reg.width == dynwidth_pkg::WIDTH_2) else $error("two-lane decode wrong");
    width1_a: assert property (@(negedge sclk_e) disable iff (ss_n)
        first_edge_s and (data_in[3:1] == 3'h7) |=>
        smp_reg.width == dynwidth_pkg::WIDTH_1) else $error("one-lane decode wrong");
    cmd_bits_a: assert property (@(negedge sclk_e) disable iff (ss_n)
        nibble_cmd_s |=> smp_reg.cmd_done && smp_reg.cmd == {$past(data_in[0], 2),
        $past(data_in[3], 2), $past(data_in[1]), $past(data_in[2])})
        else $error("command bits misplaced");
    read_drive_a: assert property (@(posedge sclk_e) disable iff (ss_n)
        drv_reg.pins.oe != 4'h0 |-> smp_reg.cmd_done && dynwidth_pkg::is_read(smp_reg.cmd))
        else $error("data lines driven outside a read");

    // System-side checks.
    flush_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && cmd_event && rep.cmd == `CMD_BUF_FLUSH |=> flush_req)
        else $error("flush not flagged");
    modem_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && byte_event && sys_reg.cmd == `CMD_WRITE_LINE_STATUS |=>
        modem_in == $past(rep.rx_byte[3:0])) else $error("modem bits not set");
    nv_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && byte_event && sys_reg.cmd == `CMD_NV_ADDR |=>
        nv_addr == $past(rep.rx_byte)) else $error("address not loaded");
    nv_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && byte_event && sys_reg.cmd == `CMD_NV_WRITE |=>
        nv_wr_strobe && nv_wr_data == $past(rep.rx_byte)) else $error("write word lost");
    idle_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ss_n && !sys_reg.idle_oe |-> data_oe == 4'h0 && !miso_oe)
        else $error("idle status driven while off");
endmodule : dynwidth_serial_slave_cmd

// [rtl/sync2.sv]
// Two-flop level synchroniser; the first stage feeds only the second.
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic en,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_type;

    sync_state_type st_reg;
    sync_state_type st_next;

    // Shift the level through both stages.
    always_comb begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    // Synchronous reset; the enable freezes the stages.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (en) begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule : sync2

// [sim/serial_master.sv]
// Bus master for the dynamic-width link; it owns the link clock and select.
module serial_master (
    output logic sclk,
    output logic ss_n,
    output logic [3:0] m_out,
    output logic [3:0] m_oe,
    input wire logic [3:0] lines,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;

    // The link clock stands still between frames until a frame sets it to its polarity while select is still high.
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        m_out = 4'h0;
        m_oe = 4'h0;
    end

    // One frame: command chunks, then one data byte unless the code is 4 (flush); an abort stops after the first data chunk.
    task automatic frame(input logic [3:0] code, input int w, input logic lsb, input logic cpol,
                         input logic [7:0] wdat, input logic abort, output logic [7:0] rdat,
                         output logic ack);
        logic [7:0] cb;
        logic rd;
        int n;
        int k;
        int b;
        int pos;
        cb = {1'b1, code[0], code[1], 1'b1, code[2], w != 4, w != 2, code[3]};
        rd = code == 4'h1 || code == 4'h2 || code == 4'h7 || code == 4'h8;
        n = (code == 4'h4) ? 16 / w : 32 / w;
        if (abort) begin
            n = 16 / w + 2;
        end
        rdat = 8'h00;
        ack = 1'b1;
        #3 sclk = cpol;
        #30 ss_n = 1'b0;
        for (int e = 0; e < n; e++) begin
            #(e == 0 ? 20 : 40) sclk = ~sclk;
            k = (e / 2) % (8 / w);
            b = e / (16 / w);
            if (e % 2 == 0) begin
                m_oe = 4'h0;
                for (int i = 0; i < w; i++) begin
                    pos = (b == 0 || lsb) ? k * w + i : 8 - w - k * w + i;
                    m_out[i] = (b == 0) ? cb[pos] : wdat[pos];
                    m_oe[i] = (b == 0) || !rd;
                end
            end else if (b > 0) begin
                if (k == 0) begin
                    ack = miso;
                end
                for (int i = 0; i < w; i++) begin
                    pos = lsb ? k * w + i : 8 - w - k * w + i;
                    rdat[pos] = lines[i];
                end
            end
        end
        #60 ss_n = 1'b1;
        m_oe = 4'h0;
    endtask : frame
endmodule : serial_master

// [sim/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [3:0] code;
        logic [2:0] w;
        logic lsb;
        logic cpol;
        logic [1:0] us;
        logic [7:0] wdat;
        logic [7:0] exp;
        logic [3:0] mask;
    } row_type;
    logic clk_sys = 1'b0;
    logic rst_n, sclk, ss_n, cfg_cpol, cfg_lsb, cfg_idle, wsa, rda, ack, miso;
    logic wr_valid, pop, flush, nv_strobe, miso_out, miso_oe;
    logic [3:0] m_out, m_oe, lines, data_out, data_oe, modem_in;
    logic [1:0] us;
    logic [7:0] wr_byte, nv_addr, nv_wr_data, rdat, diff, seen, e8;
    int miscompares = 0;
    int n_checks = 0;
    int cnt[4] = '{0, 0, 0, 0};
    int base[4];
    row_type rows[17] = '{
        '{4'h0, 3'h4, 1'b1, 1'b0, 2'h0, 8'h4d, 8'h4d, 4'h1},
        '{4'h0, 3'h1, 1'b0, 1'b1, 2'h0, 8'hb2, 8'hb2, 4'h1},
        '{4'h0, 3'h2, 1'b1, 1'b1, 2'h0, 8'h1e, 8'h1e, 4'h1},
        '{4'h1, 3'h4, 1'b0, 1'b0, 2'h0, 8'h00, 8'hc3, 4'h2},
        '{4'h1, 3'h1, 1'b1, 1'b1, 2'h0, 8'h00, 8'hc3, 4'h2},
        '{4'h2, 3'h2, 1'b0, 1'b0, 2'h0, 8'h00, 8'h02, 4'h0},
        '{4'h3, 3'h4, 1'b1, 1'b1, 2'h0, 8'h0a, 8'h0a, 4'h0},
        '{4'h4, 3'h1, 1'b0, 1'b0, 2'h0, 8'h00, 8'h00, 4'h4},
        '{4'h5, 3'h2, 1'b1, 1'b0, 2'h0, 8'h81, 8'h81, 4'h0},
        '{4'h6, 3'h4, 1'b0, 1'b1, 2'h0, 8'h3c, 8'h3c, 4'h8},
        '{4'h7, 3'h1, 1'b1, 1'b0, 2'h0, 8'h00, 8'hdb, 4'h0},
        '{4'h8, 3'h4, 1'b1, 1'b0, 2'h0, 8'h00, 8'h00, 4'h0},
        '{4'h8, 3'h2, 1'b0, 1'b1, 2'h1, 8'h00, 8'h01, 4'h0},
        '{4'h8, 3'h1, 1'b1, 1'b0, 2'h2, 8'h00, 8'h02, 4'h0},
        '{4'h8, 3'h4, 1'b0, 1'b1, 2'h3, 8'h00, 8'h03, 4'h0},
        '{4'h9, 3'h4, 1'b1, 1'b0, 2'h0, 8'h55, 8'h55, 4'h0},
        '{4'hf, 3'h1, 1'b0, 1'b1, 2'h0, 8'haa, 8'haa, 4'h0}};

    // Undriven lanes are pulled up, so a released lane always reads high.
    assign lines = (data_oe & data_out) | (~data_oe & m_oe & m_out) | (~data_oe & ~m_oe);
    assign miso = miso_oe ? miso_out : 1'b1;

    // Clock of the system side.
    always #4 clk_sys = ~clk_sys;

    // Pulses are counted so that a doubled pulse shows up as a count of two.
    always @(posedge clk_sys) begin
        cnt[0] <= cnt[0] + int'(wr_valid);
        cnt[1] <= cnt[1] + int'(pop);
        cnt[2] <= cnt[2] + int'(flush);
        cnt[3] <= cnt[3] + int'(nv_strobe);
    end

    dynwidth_serial_slave_cmd i_dynwidth_serial_slave_cmd (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(1'b1), .sclk(sclk), .ss_n(ss_n), .data_in(lines), .data_out(data_out),
        .data_oe(data_oe), .miso_out(miso_out), .miso_oe(miso_oe), .cfg_cpol(cfg_cpol),
        .cfg_lsb_first(cfg_lsb), .cfg_idle_status_en(cfg_idle), .write_space_avail(wsa),
        .read_data_avail(rda), .rd_byte(8'hc3), .nv_rd_data(nv_addr ^ 8'h5a), .rts(1'b1),
        .dtr(1'b0), .usb_state(us), .wr_byte(wr_byte), .wr_byte_valid(wr_valid),
        .rd_byte_pop(pop), .modem_in(modem_in), .flush_req(flush), .nv_addr(nv_addr),
        .nv_wr_data(nv_wr_data), .nv_wr_strobe(nv_strobe));

    serial_master i_serial_master (.sclk(sclk), .ss_n(ss_n), .m_out(m_out), .m_oe(m_oe),
        .lines(lines), .miso(miso));

    task check(input logic [7:0] got, input logic [7:0] want);
        n_checks++;
        if (got !== want) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, want);
        end
    endtask : check

    task results;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    // Config is set while select is idle, then given time to cross before the frame.
    task automatic run(input row_type r, input logic abort);
        @(posedge clk_sys);
        cfg_cpol <= r.cpol;
        cfg_lsb <= r.lsb;
        us <= r.us;
        repeat (8) @(posedge clk_sys);
        base = cnt;
        i_serial_master.frame(r.code, int'(r.w), r.lsb, r.cpol, r.wdat, abort, rdat, ack);
        repeat (10) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            diff[2 * i +: 2] = 2'(cnt[i] - base[i]);
        end
    endtask : run

    // A hung frame would otherwise stall the run for good.
    initial begin
        repeat (100000) @(posedge clk_sys);
        miscompares++;
        results();
    end

    initial begin
        {rst_n, cfg_cpol, cfg_lsb, us} = 5'h00;
        {cfg_idle, wsa, rda} = 3'h7;
        repeat (5) @(posedge clk_sys);
        check(nv_addr | wr_byte | {data_oe, 3'h0, miso_oe}, 8'h00);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check(8'({data_oe[0], data_out[0], miso_oe, miso_out}), 8'h0f);
        wsa <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(8'({data_oe[0], data_out[0], miso_oe, miso_out}), 8'h0b);
        wsa <= 1'b1;
        cfg_idle <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check(8'({data_oe, miso_oe}), 8'h00);
        $display("idle status test done");
        foreach (rows[j]) begin
            run(rows[j], 1'b0);
            case (rows[j].code)
                4'h0: seen = wr_byte;
                4'h3: seen = {4'h0, modem_in};
                4'h5: seen = nv_addr;
                4'h6: seen = nv_wr_data;
                4'h1, 4'h2, 4'h7, 4'h8: seen = rdat;
                default: seen = rdat;
            endcase
            for (int i = 0; i < 4; i++) begin
                e8[2 * i +: 2] = {1'b0, rows[j].mask[i]};
            end
            check(seen, rows[j].exp);
            check(diff, e8);
            if (rows[j].code != 4'h4 && rows[j].code < 4'h9) begin
                check(8'(ack), 8'h00);
            end
            $display("row %0d done", j);
        end
        wsa <= 1'b0;
        run(rows[0], 1'b0);
        check(8'(ack), 8'h01);
        wsa <= 1'b1;
        $display("refusal test done");
        run(rows[1], 1'b1);
        check(diff, 8'h00);
        check(wr_byte, 8'h4d);
        run(rows[2], 1'b0);
        check(wr_byte, 8'h1e);
        $display("abort test done");
        results();
    end
endmodule : tb
